//--- design/lbme_map.svh
// Opcodes, machine-cycle timing and reset values for the long branch unit.
// What this block does
// - Long call return address is the program counter plus three.
// - Push return low byte at SP+1, high byte at SP+2; SP gains two.
// - Then load PC high from byte two, low from byte three, fetch.
// - Long call opcode 00010010, three bytes, two machine cycles.
// - Call target spans full 16-bit space; no flag changes.
// - Long jump loads PC from bytes two and three; stack untouched.
// - Long jump is three bytes long and takes two machine cycles.
// - Byte copy writes destination only; source and flags unchanged.
// - Byte copy decoder knows nine source/destination pairings.
// - Direct byte into A: opcode 11100101, two bytes, one cycle.
// - Direct copy of A into A is invalid; A is undefined after it. The code keeps A unchanged for it.
`ifndef LBME_MAP_SVH
`define LBME_MAP_SVH

`define LBME_OP_LONG_SUBROUTINE_CALL     8'h12
`define LBME_OP_LONG_JUMP      8'h02
`define LBME_OP_A_DIRECT  8'he5
`define LBME_OP_A_BANK    5'h1d
`define LBME_OP_A_IND     7'h73
`define LBME_OP_A_IMM     8'h74
`define LBME_OP_BANK_A    5'h1f
`define LBME_OP_BANK_DIR  5'h15
`define LBME_OP_BANK_IMM  5'h0f
`define LBME_OP_DIR_A     8'hf5
`define LBME_OP_DIR_BANK  5'h11

`define LBME_DIR_ACC      8'he0
`define LBME_DIR_SP       8'h81

`define LBME_MC_CLKS      12
`define LBME_CYC_LONG     2
`define LBME_CYC_MOVE     1
`define LBME_RET_OFFSET   16'h0003

`define LBME_RST_PC       16'h0000
`define LBME_RST_SP       8'h07
`define LBME_RST_ACC      8'h00

`endif

//--- design/lbme_pkg.sv
// Types shared by the long branch and byte copy unit.
package lbme_pkg;

  typedef enum logic [3:0] {
    ST_FETCH,
    ST_WAIT,
    ST_DECODE,
    ST_BYTE2,
    ST_BYTE3,
    ST_PUSH_LO,
    ST_PUSH_HI,
    ST_DATA,
    ST_PAD
  } lbme_state_t;

  typedef enum logic [3:0] {
    PAIR_NONE,
    PAIR_A_BANK,
    PAIR_A_DIRECT,
    PAIR_A_IND,
    PAIR_A_IMM,
    PAIR_BANK_A,
    PAIR_BANK_DIRECT,
    PAIR_BANK_IMM,
    PAIR_DIRECT_A,
    PAIR_DIRECT_BANK,
    PAIR_DIRECT_DIRECT,
    PAIR_DIRECT_IND,
    PAIR_DIRECT_IMM,
    PAIR_IND_A,
    PAIR_IND_DIRECT,
    PAIR_IND_IMM
  } lbme_pair_t;

  typedef struct packed {
    lbme_state_t state;
    lbme_state_t ret;
    logic [15:0] pc;
    logic [7:0]  sp;
    logic [7:0]  acc;
    logic [7:0]  opcode;
    logic [7:0]  byte2;
    logic [7:0]  cnt;
    logic [7:0]  limit;
    logic [15:0] code_addr;
    logic [7:0]  data_addr;
    logic [7:0]  data_wdata;
    logic        data_we;
    logic        done;
    logic        foreign;
    lbme_pair_t  pair;
  } lbme_core_t;

endpackage

//--- design/lbme_exec.sv
// Fetch, decode and execute of long call, long jump and direct or register-bank copies into A.
`timescale 1ns/1ps
`include "lbme_map.svh"

module lbme_exec #(
  parameter int MC_CLKS = `LBME_MC_CLKS
) (
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // Program memory, read data one cycle after the address.
  output logic [15:0]      code_addr,
  input  wire logic [7:0]  code_data,
  // Internal data memory and special registers, same timing.
  output logic [7:0]       data_addr,
  output logic [7:0]       data_wdata,
  output logic             data_we,
  input  wire logic [7:0]  data_rdata,
  // Register bank select from the status word.
  input  wire logic [1:0]  bank_sel,
  // Processor state.
  output logic [15:0]      program_counter,
  output logic [7:0]       stack_pointer,
  output logic [7:0]       work_register_a,
  // Instruction status.
  output logic             instr_done,
  output logic             instr_foreign,
  output lbme_pkg::lbme_pair_t copy_pairing
);

  lbme_pkg::lbme_core_t core_reg;
  lbme_pkg::lbme_core_t core_next;

  localparam logic [7:0] LONG_CLKS = 8'(`LBME_CYC_LONG * MC_CLKS);
  localparam logic [7:0] MOVE_CLKS = 8'(`LBME_CYC_MOVE * MC_CLKS);

  // Classifies a copy opcode into its addressing pairing.
  function automatic lbme_pkg::lbme_pair_t pair_of(input logic [7:0] op);
    lbme_pkg::lbme_pair_t p;
    p = lbme_pkg::PAIR_NONE;
    if (op[7:3] == `LBME_OP_A_BANK) begin
      p = lbme_pkg::PAIR_A_BANK;
    end else if (op == `LBME_OP_A_DIRECT) begin
      p = lbme_pkg::PAIR_A_DIRECT;
    end else if (op[7:1] == `LBME_OP_A_IND) begin
      p = lbme_pkg::PAIR_A_IND;
    end else if (op == `LBME_OP_A_IMM) begin
      p = lbme_pkg::PAIR_A_IMM;
    end else if (op[7:3] == `LBME_OP_BANK_A) begin
      p = lbme_pkg::PAIR_BANK_A;
    end else if (op[7:3] == `LBME_OP_BANK_DIR) begin
      p = lbme_pkg::PAIR_BANK_DIRECT;
    end else if (op[7:3] == `LBME_OP_BANK_IMM) begin
      p = lbme_pkg::PAIR_BANK_IMM;
    end else if (op == `LBME_OP_DIR_A) begin
      p = lbme_pkg::PAIR_DIRECT_A;
    end else if (op[7:3] == `LBME_OP_DIR_BANK) begin
      p = lbme_pkg::PAIR_DIRECT_BANK;
    end
    return p;
  endfunction

  logic [15:0] ret_addr;

  // The return address is formed from the opcode address, so it is valid
  // throughout the call no matter how far operand fetch has advanced.
  assign ret_addr = core_reg.pc + `LBME_RET_OFFSET;

  always_comb begin
    core_next         = core_reg;
    core_next.data_we = 1'b0;
    core_next.done    = 1'b0;
    core_next.foreign = 1'b0;
    core_next.cnt     = core_reg.cnt + 8'h01;
    case (core_reg.state)
      lbme_pkg::ST_FETCH: begin
        core_next.cnt       = 8'h00;
        core_next.code_addr = core_reg.pc;
        core_next.ret       = lbme_pkg::ST_DECODE;
        core_next.state     = lbme_pkg::ST_WAIT;
      end
      lbme_pkg::ST_WAIT: begin
        core_next.state = core_reg.ret;
      end
      lbme_pkg::ST_DECODE: begin
        core_next.opcode = code_data;
        core_next.pair   = pair_of(code_data);
        core_next.state  = lbme_pkg::ST_PAD;
        if (code_data == `LBME_OP_LONG_SUBROUTINE_CALL ||
            code_data == `LBME_OP_LONG_JUMP) begin
          core_next.limit     = LONG_CLKS;
          core_next.code_addr = core_reg.pc + 16'h0001;
          core_next.ret       = lbme_pkg::ST_BYTE2;
          core_next.state     = lbme_pkg::ST_WAIT;
        end else if (code_data == `LBME_OP_A_DIRECT) begin
          core_next.limit     = MOVE_CLKS;
          core_next.code_addr = core_reg.pc + 16'h0001;
          core_next.ret       = lbme_pkg::ST_BYTE2;
          core_next.state     = lbme_pkg::ST_WAIT;
        end else if (code_data[7:3] == `LBME_OP_A_BANK) begin
          core_next.limit     = MOVE_CLKS;
          core_next.data_addr = {3'h0, bank_sel, code_data[2:0]};
          core_next.ret       = lbme_pkg::ST_DATA;
          core_next.state     = lbme_pkg::ST_WAIT;
        end else begin
          // Anything else belongs to a neighbouring unit; it is flagged
          // and stepped over as one byte so the core never hangs.
          core_next.limit   = MOVE_CLKS;
          core_next.pc      = core_reg.pc + 16'h0001;
          core_next.foreign = 1'b1;
        end
      end
      lbme_pkg::ST_BYTE2: begin
        core_next.byte2 = code_data;
        if (core_reg.opcode == `LBME_OP_A_DIRECT) begin
          core_next.data_addr = code_data;
          core_next.ret       = lbme_pkg::ST_DATA;
        end else begin
          core_next.code_addr = core_reg.pc + 16'h0002;
          core_next.ret       = lbme_pkg::ST_BYTE3;
        end
        core_next.state = lbme_pkg::ST_WAIT;
      end
      lbme_pkg::ST_BYTE3: begin
        if (core_reg.opcode == `LBME_OP_LONG_SUBROUTINE_CALL) begin
          core_next.state = lbme_pkg::ST_PUSH_LO;
        end else begin
          core_next.pc    = {core_reg.byte2, code_data};
          core_next.state = lbme_pkg::ST_PAD;
        end
      end
      lbme_pkg::ST_PUSH_LO: begin
        // Byte three is still on the code bus; it is taken with the high
        // push so no extra holding register is needed.
        core_next.sp         = core_reg.sp + 8'h01;
        core_next.data_addr  = core_reg.sp + 8'h01;
        core_next.data_wdata = ret_addr[7:0];
        core_next.data_we    = 1'b1;
        core_next.state      = lbme_pkg::ST_PUSH_HI;
      end
      lbme_pkg::ST_PUSH_HI: begin
        core_next.sp         = core_reg.sp + 8'h01;
        core_next.data_addr  = core_reg.sp + 8'h01;
        core_next.data_wdata = ret_addr[15:8];
        core_next.data_we    = 1'b1;
        core_next.pc         = {core_reg.byte2, code_data};
        core_next.state      = lbme_pkg::ST_PAD;
      end
      lbme_pkg::ST_DATA: begin
        if (core_reg.opcode == `LBME_OP_A_DIRECT) begin
          core_next.pc = core_reg.pc + 16'h0002;
          if (core_reg.byte2 == `LBME_DIR_ACC) begin
            core_next.acc = core_reg.acc;
          end else if (core_reg.byte2 == `LBME_DIR_SP) begin
            core_next.acc = core_reg.sp;
          end else begin
            core_next.acc = data_rdata;
          end
        end else begin
          core_next.pc  = core_reg.pc + 16'h0001;
          core_next.acc = data_rdata;
        end
        core_next.state = lbme_pkg::ST_PAD;
      end
      lbme_pkg::ST_PAD: begin
        // Stretch every instruction to its full machine-cycle count. The
        // count lags the fetch clock by one, so the last pad clock sees
        // limit minus two and the next fetch lands exactly on the limit.
        if (core_reg.cnt >= core_reg.limit - 8'h02) begin
          core_next.done  = 1'b1;
          core_next.state = lbme_pkg::ST_FETCH;
        end
      end
      default: begin
        core_next.state = lbme_pkg::ST_FETCH;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      core_reg            <= '0;
      core_reg.state      <= lbme_pkg::ST_FETCH;
      core_reg.ret        <= lbme_pkg::ST_FETCH;
      core_reg.pc         <= `LBME_RST_PC;
      core_reg.sp         <= `LBME_RST_SP;
      core_reg.acc        <= `LBME_RST_ACC;
      core_reg.pair       <= lbme_pkg::PAIR_NONE;
    end else begin
      core_reg <= core_next;
    end
  end

  assign code_addr       = core_reg.code_addr;
  assign data_addr       = core_reg.data_addr;
  assign data_wdata      = core_reg.data_wdata;
  assign data_we         = core_reg.data_we;
  assign program_counter = core_reg.pc;
  assign stack_pointer   = core_reg.sp;
  assign work_register_a = core_reg.acc;
  assign instr_done      = core_reg.done;
  assign instr_foreign   = core_reg.foreign;
  assign copy_pairing    = core_reg.pair;

endmodule

//--- dv/lbme_sva.sv
// Port checks for the long branch and byte copy unit.
`timescale 1ns/1ps
module lbme_sva #(
  parameter int MC_CLKS = 12
) (
  // Clock and reset.
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  // Observed ports.
  input wire logic [7:0]  code_data,
  input wire logic [7:0]  data_addr,
  input wire logic [7:0]  data_wdata,
  input wire logic        data_we,
  input wire logic [15:0] program_counter,
  input wire logic [7:0]  stack_pointer,
  input wire logic [7:0]  work_register_a,
  input wire logic        instr_done
);
  localparam int LONG = 2 * MC_CLKS;
  logic [15:0] ret;
  logic [7:0]  ret_hi;
  logic [7:0]  cnt_reg;
  logic        wrote_reg;
  assign ret = program_counter + 16'h0003;
  assign ret_hi = ret[15:8];
  // Counts clocks from the fetch clock, so an instruction shows its full
  // length on the clock of its done pulse, the first one after reset too.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt_reg   <= 8'h00;
      wrote_reg <= 1'b0;
    end else if (instr_done) begin
      cnt_reg   <= 8'h01;
      wrote_reg <= 1'b0;
    end else begin
      cnt_reg   <= cnt_reg + 8'h01;
      wrote_reg <= wrote_reg | data_we;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_push;
    data_we ##1 data_we ##1 !data_we;
  endsequence
  property p_push_lo;
    $rose(data_we) |-> data_wdata == ret[7:0] && data_addr == stack_pointer;
  endproperty
  a_push_lo: assert property (p_push_lo)
    else $error("low return byte wrong");
  property p_push_pair;
    $rose(data_we) |-> s_push;
  endproperty
  a_push_pair: assert property (p_push_pair)
    else $error("push is not two writes");
  property p_push_hi;
    data_we && $past(data_we) |-> data_addr == $past(data_addr) + 8'h01
      && stack_pointer == data_addr && data_wdata == $past(ret_hi);
  endproperty
  a_push_hi: assert property (p_push_hi)
    else $error("high return byte wrong");
  property p_target;
    data_we && $past(data_we) |->
      program_counter == {$past(code_data, 5), $past(code_data, 3)};
  endproperty
  a_target: assert property (p_target)
    else $error("call target wrong");
  property p_long;
    instr_done && wrote_reg |-> cnt_reg == LONG;
  endproperty
  a_long: assert property (p_long)
    else $error("call length wrong");
  property p_done;
    instr_done |-> cnt_reg == MC_CLKS || cnt_reg == LONG;
  endproperty
  a_done: assert property (p_done)
    else $error("instruction length wrong");
  property p_sp;
    $changed(stack_pointer) |-> data_we;
  endproperty
  a_sp: assert property (p_sp)
    else $error("stack pointer moved without push");
  property p_acc;
    $changed(work_register_a) |-> ##[1:MC_CLKS] instr_done;
  endproperty
  a_acc: assert property (p_acc)
    else $error("accumulator changed outside a copy");
endmodule

bind lbme_exec lbme_sva #(.MC_CLKS(MC_CLKS)) u_sva (.sys_clk, .sys_rst,
  .code_data, .data_addr, .data_wdata, .data_we, .program_counter,
  .stack_pointer, .work_register_a, .instr_done);

//--- dv/lbme_mem.sv
// Program memory and internal data memory beside the unit.
`timescale 1ns/1ps
module lbme_mem (
  // Clock.
  input wire logic        sys_clk,
  // Program side.
  input wire logic [15:0] code_addr,
  output logic [7:0]      code_data,
  // Data side.
  input wire logic [7:0]  data_addr,
  input wire logic [7:0]  data_wdata,
  input wire logic        data_we,
  output logic [7:0]      data_rdata
);
  logic [7:0] rom [65536];
  logic [7:0] ram [256];
  // Both reads answer one cycle after the address.
  always @(posedge sys_clk) begin
    code_data <= rom[code_addr];
    data_rdata <= ram[data_addr];
    if (data_we) ram[data_addr] <= data_wdata;
  end
endmodule

//--- dv/test_long_branch_and_move_exec.sv
// Self-checking bench for the long branch and byte copy unit.
`timescale 1ns/1ps
module test_long_branch_and_move_exec;
  typedef struct {
    logic [15:0] pc; logic [7:0] sp; logic [7:0] acc; bit chk;
    lbme_pkg::lbme_pair_t pr;
  } lbme_note_t;
  logic        sys_clk, sys_rst, data_we, instr_done, instr_foreign;
  logic [1:0]  bank_sel;
  logic [15:0] code_addr, program_counter, wp, t, ret;
  logic [7:0]  code_data, data_addr, data_wdata, data_rdata, seed, n;
  logic [7:0]  stack_pointer, work_register_a;
  logic [7:0]  exp_ram [256];
  lbme_pkg::lbme_pair_t copy_pairing;
  lbme_note_t  notes[$];
  int          fail_count, compares, cyc, foreigns;
  lbme_exec #(.MC_CLKS(10)) DUT (.sys_clk, .sys_rst, .code_addr, .code_data,
    .data_addr, .data_wdata, .data_we, .data_rdata, .bank_sel,
    .program_counter, .stack_pointer, .work_register_a, .instr_done,
    .instr_foreign, .copy_pairing);
  lbme_mem u_mem (.sys_clk, .code_addr, .code_data, .data_addr,
    .data_wdata, .data_we, .data_rdata);
  function automatic logic [7:0] rnd();
    seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
    return seed;
  endfunction
  task automatic emit(input logic [7:0] b);
    u_mem.rom[wp] = b;
    wp++;
  endtask
  task automatic note(input logic [15:0] pc, input logic [7:0] sp,
      input logic [7:0] acc, input bit chk, input lbme_pkg::lbme_pair_t pr);
    notes.push_back(lbme_note_t'{pc, sp, acc, chk, pr});
  endtask
  task automatic cmp_state(input lbme_note_t e);
    compares++;
    if (program_counter !== e.pc || stack_pointer !== e.sp ||
        copy_pairing !== e.pr || (e.chk && work_register_a !== e.acc)) begin
      fail_count++;
      $display("unexpected at %0t: pc %h sp %h a %h", $time,
        program_counter, stack_pointer, work_register_a);
    end
  endtask
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] e);
    compares++;
    if (got !== e) begin
      fail_count++;
      $display("unexpected at %0t: stack byte %h", $time, got);
    end
  endtask
  task automatic cmp_count(input int got, input int e);
    compares++;
    if (got !== e) begin
      fail_count++;
      $display("unexpected at %0t: foreign count %0d", $time, got);
    end
  endtask
  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      print_verdict();
    end
  end
  always @(negedge sys_clk) begin
    if (instr_foreign === 1'b1)
      foreigns++;
    if (instr_done === 1'b1 && notes.size() > 0)
      cmp_state(notes.pop_front());
  end
  initial begin
    sys_rst = 1'b1;
    seed = 8'h46;
    for (int i = 0; i < 65536; i++) u_mem.rom[i] = 8'ha5;
    for (int i = 0; i < 256; i++) begin
      exp_ram[i] = rnd();
      u_mem.ram[i] = exp_ram[i];
    end
    n = rnd();
    bank_sel = n[4:3];
    t = {8'hff, rnd() & 8'h7f};
    wp = 16'h0000;
    emit(8'h12); emit(8'h12); emit(8'h34);
    exp_ram[8] = 8'h03;
    exp_ram[9] = 8'h00;
    note(16'h1234, 8'h09, 8'h00, 1, lbme_pkg::PAIR_NONE);
    wp = 16'h1234;
    emit(8'he5); emit(8'h30);
    note(16'h1236, 8'h09, exp_ram[8'h30], 1, lbme_pkg::PAIR_A_DIRECT);
    emit({5'h1d, n[2:0]});
    note(16'h1237, 8'h09, exp_ram[{3'h0, n[4:0]}], 1, lbme_pkg::PAIR_A_BANK);
    emit(8'he5); emit(8'he0);
    note(16'h1239, 8'h09, 8'h00, 0, lbme_pkg::PAIR_A_DIRECT);
    emit(8'he5); emit(8'h81);
    note(16'h123b, 8'h09, 8'h09, 1, lbme_pkg::PAIR_A_DIRECT);
    emit(8'h02); emit(t[15:8]); emit(t[7:0]);
    note(t, 8'h09, 8'h09, 1, lbme_pkg::PAIR_NONE);
    wp = t;
    emit(8'h12); emit(8'h00); emit(8'h40);
    ret = t + 16'h0003;
    exp_ram[8'h0a] = ret[7:0];
    exp_ram[8'h0b] = ret[15:8];
    note(16'h0040, 8'h0b, 8'h09, 1, lbme_pkg::PAIR_NONE);
    note(16'h0041, 8'h0b, 8'h09, 1, lbme_pkg::PAIR_NONE);
    repeat (2) @(negedge sys_clk);
    sys_rst = 1'b0;
    while (notes.size() > 0) @(negedge sys_clk);
    for (int i = 8; i < 12; i++)
      cmp_byte(u_mem.ram[i], exp_ram[i]);
    cmp_count(foreigns, 1);
    print_verdict();
  end
endmodule
